// >>> hdl/rxdma_pkg.sv
// Notes on behaviour
// - enable bit low keeps channel idle
// - request only for complete buffered message
// - data flows framer buffer to memory only
// - transfer starts with request driven low
// - read strobe mode: word per strobe pulse
// - direction mode: word per write strobe pulse while rd is high
// - type bit selects strobe or direction function
// - three-bit code picks served line channel
// - reset bit rising edge resets the channel
package rxdma_pkg;
  localparam logic [11:0] RXDMA_CFG_ADDR = 12'h0000;
  localparam logic [11:0] RXDMA_STAT_ADDR = 12'h0004;
  localparam logic [11:0] RXDMA_MSG_ADDR = 12'h0008;
  localparam int RXDMA_ADDR_W = 12;
  localparam int RXDMA_CFG_RST_BIT = 7;
  localparam int RXDMA_CFG_ENB_BIT = 6;
  localparam int RXDMA_CFG_TYPE_BIT = 5;
  localparam logic [7:0] RXDMA_CFG_MASK = 8'hE7;
  localparam logic [7:0] RXDMA_CFG_RESET = 8'h00;
  localparam logic [2:0] RXDMA_CHAN_0 = 3'h0;
  localparam logic [2:0] RXDMA_CHAN_2 = 3'h1;
  localparam int RXDMA_DEPTH = 16;
  localparam int RXDMA_IDX_W = 4;
  localparam int RXDMA_CNT_W = 5;
  localparam logic [1:0] RXDMA_RESP_OKAY = 2'b00;
  localparam logic [1:0] RXDMA_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {RXDMA_IDLE, RXDMA_REQ, RXDMA_XFER} rxdma_state_t;
endpackage

// >>> hdl/rxdma_cfg_if.sv
`timescale 1ns/1ps
interface rxdma_cfg_if;
  logic enable;
  logic dir_mode;
  logic soft_reset;
  logic [2:0] chan_sel;
  logic busy;
  logic [4:0] left;
  modport regs (output enable, output dir_mode, output soft_reset, output chan_sel, input busy, input left);
  modport core (input enable, input dir_mode, input soft_reset, input chan_sel, output busy, output left);
endinterface

// >>> hdl/rxdma_core.sv
`timescale 1ns/1ps
module rxdma_core
  import rxdma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  rxdma_cfg_if.core cfg,
  input wire logic [7:0] msg_data [RXDMA_DEPTH],
  input wire logic [4:0] msg_len,
  input wire logic msg_ready,
  output logic msg_taken,
  input wire logic ack_n,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic req_n,
  output logic [7:0] dout,
  output logic dout_oe
);
  rxdma_state_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic strobe_q;
  // strobe selection by pin function
  wire logic strobe_n = cfg.dir_mode ? wr_n : rd_n;
  wire logic dir_read = cfg.dir_mode ? rd_n : 1'b1; // direction: rd high means read
  wire logic strobe_on = !strobe_n && !ack_n && dir_read; // acknowledged read strobe on the bus
  wire logic active = strobe_on && state_q == RXDMA_XFER;
  wire logic strobe_end = !active && strobe_q;
  wire logic chan_ok = cfg.chan_sel == RXDMA_CHAN_0 || cfg.chan_sel == RXDMA_CHAN_2;
  wire logic last = strobe_end && cnt_q == msg_len - 5'd1;
  // next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      // the finished message still shows ready for one cycle while msg_taken clears it
      RXDMA_IDLE: if (cfg.enable && chan_ok && msg_ready && !msg_taken) begin
        state_d = RXDMA_REQ;
        cnt_d = '0;
      end
      RXDMA_REQ: if (!ack_n) state_d = RXDMA_XFER;
      RXDMA_XFER: if (strobe_end) begin
        cnt_d = cnt_q + 5'd1;
        if (last) state_d = RXDMA_IDLE;
      end
      default: state_d = RXDMA_IDLE;
    endcase
    if (!cfg.enable || cfg.soft_reset) state_d = RXDMA_IDLE;
  end
  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RXDMA_IDLE;
      cnt_q <= '0;
      strobe_q <= 1'b0;
      req_n <= 1'b1;
      dout <= 8'h00;
      dout_oe <= 1'b0;
      msg_taken <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      strobe_q <= active;
      req_n <= !(state_d != RXDMA_IDLE);
      dout <= msg_data[cnt_d[RXDMA_IDX_W-1:0]];
      dout_oe <= state_d == RXDMA_XFER && strobe_on;
      msg_taken <= last && !cfg.soft_reset;
    end
  end
  assign cfg.busy = state_q != RXDMA_IDLE;
  assign cfg.left = msg_len - cnt_q;
endmodule

// >>> hdl/rxdma_top.sv
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rxdma_top
  import rxdma_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [RXDMA_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [RXDMA_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [7:0] MSG_BYTE,
  input wire logic MSG_BYTE_VALID,
  input wire logic MSG_END,
  output logic MSG_FULL,
  input wire logic READ_TRANSFER_ACK_N,
  input wire logic RD_N,
  input wire logic WR_N,
  output logic READ_TRANSFER_REQUEST_N,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE
);
  logic rst_s1_q, rst_s2_q;
  logic [7:0] cfg_q;
  logic rst_bit_q;
  logic soft_rst_q;
  logic aw_q, w_q;
  logic [RXDMA_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [7:0] buf_q [RXDMA_DEPTH];
  logic [4:0] wr_cnt_q;
  logic [4:0] len_q;
  logic ready_q;
  logic taken;
  rxdma_cfg_if cfg_bus ();

  // reset release through two flops
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic rst_n = rst_s2_q;

  // register map decode, shared by the write and read paths
  function automatic logic is_mapped(input logic [RXDMA_ADDR_W-1:0] a);
    return a == RXDMA_CFG_ADDR || a == RXDMA_STAT_ADDR || a == RXDMA_MSG_ADDR;
  endfunction

  // write decode
  wire logic wr_go = aw_q && w_q && !S_AXI_BVALID;
  wire logic wr_cfg = wr_go && awaddr_q == RXDMA_CFG_ADDR && wstrb_q[0];
  wire logic wr_ok = is_mapped(awaddr_q);
  wire logic [7:0] cfg_new = wdata_q[7:0] & RXDMA_CFG_MASK;
  wire logic rst_rise = wr_cfg && cfg_new[RXDMA_CFG_RST_BIT] && !rst_bit_q;
  wire logic rd_ok = is_mapped(S_AXI_ARADDR);
  wire logic [31:0] rd_mux = S_AXI_ARADDR == RXDMA_CFG_ADDR ? {24'h00_0000, cfg_q} :
                             S_AXI_ARADDR == RXDMA_STAT_ADDR ? {27'h000_0000, 1'b0, 1'b0, soft_rst_q,
                                                               ready_q, cfg_bus.busy} :
                             S_AXI_ARADDR == RXDMA_MSG_ADDR ? {16'h0000, 3'h0, cfg_bus.left, 3'h0, len_q} :
                             32'h0000_0000;

  // axi write channel: next values of the capture flags and of the response valid
  wire logic aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  wire logic w_take = S_AXI_WVALID && S_AXI_WREADY;
  wire logic aw_d = !wr_go && (aw_q || aw_take);
  wire logic w_d = !wr_go && (w_q || w_take);
  wire logic bvalid_d = wr_go || (S_AXI_BVALID && !S_AXI_BREADY);

  // axi write channel capture; ready flops follow the next flag values so no output is combinational
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RXDMA_RESP_OKAY;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      S_AXI_AWREADY <= !aw_d && !bvalid_d;
      S_AXI_WREADY <= !w_d && !bvalid_d;
      S_AXI_BVALID <= bvalid_d;
      if (aw_take) begin
        awaddr_q <= S_AXI_AWADDR;
      end
      if (w_take) begin
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        S_AXI_BRESP <= wr_ok ? RXDMA_RESP_OKAY : RXDMA_RESP_SLVERR;
      end
    end
  end

  // axi read channel; address ready is low exactly while a read answer stands
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RXDMA_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RDATA <= rd_mux;
      S_AXI_RRESP <= rd_ok ? RXDMA_RESP_OKAY : RXDMA_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // configuration register and reset edge pulse
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= RXDMA_CFG_RESET;
      rst_bit_q <= 1'b0;
      soft_rst_q <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_q <= cfg_new;
        rst_bit_q <= cfg_new[RXDMA_CFG_RST_BIT];
      end
      soft_rst_q <= rst_rise;
    end
  end
  assign cfg_bus.enable = cfg_q[RXDMA_CFG_ENB_BIT];
  assign cfg_bus.dir_mode = cfg_q[RXDMA_CFG_TYPE_BIT];
  assign cfg_bus.soft_reset = soft_rst_q;
  assign cfg_bus.chan_sel = cfg_q[2:0];

  // a byte is stored only while no finished message waits and room is left
  wire logic byte_ok = !ready_q && MSG_BYTE_VALID && wr_cnt_q < RXDMA_CNT_W'(RXDMA_DEPTH);

  // receive message store, filled by the hdlc side
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      wr_cnt_q <= '0;
      len_q <= '0;
      ready_q <= 1'b0;
      MSG_FULL <= 1'b0;
    end else if (soft_rst_q || taken) begin
      wr_cnt_q <= '0;
      ready_q <= 1'b0;
      MSG_FULL <= 1'b0;
    end else if (byte_ok) begin
      wr_cnt_q <= wr_cnt_q + 5'd1;
      if (MSG_END) begin
        ready_q <= 1'b1;
        len_q <= wr_cnt_q + 5'd1;
        MSG_FULL <= 1'b1;
      end
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (byte_ok) begin
      buf_q[wr_cnt_q[RXDMA_IDX_W-1:0]] <= MSG_BYTE;
    end
  end

  rxdma_core u_core (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .cfg(cfg_bus.core),
    .msg_data(buf_q),
    .msg_len(len_q),
    .msg_ready(ready_q),
    .msg_taken(taken),
    .ack_n(READ_TRANSFER_ACK_N),
    .rd_n(RD_N),
    .wr_n(WR_N),
    .req_n(READ_TRANSFER_REQUEST_N),
    .dout(DATA_OUT),
    .dout_oe(DATA_OE)
  );
endmodule

// >>> dv/rxdma_chk.sv
`timescale 1ns/1ps
module rxdma_chk (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic MSG_BYTE_VALID,
  input wire logic MSG_END,
  input wire logic MSG_FULL,
  input wire logic READ_TRANSFER_ACK_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic READ_TRANSFER_REQUEST_N,
  input wire logic DATA_OE,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY
);
  // every check samples on the system clock and sleeps during reset
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  chk_req_whole: assert property (!READ_TRANSFER_REQUEST_N |-> MSG_FULL)
    else $error("request without a whole message");
  chk_full_set: assert property (MSG_BYTE_VALID && MSG_END && !MSG_FULL |=> MSG_FULL)
    else $error("complete message not flagged");
  chk_oe_cause: assert property ($rose(DATA_OE) |-> !$past(READ_TRANSFER_ACK_N) && !($past(RD_N) && $past(WR_N)))
    else $error("bus driven without ack and strobe");
  chk_oe_req: assert property (DATA_OE |-> !$past(READ_TRANSFER_REQUEST_N))
    else $error("bus driven outside a request");
  chk_oe_drop: assert property (DATA_OE && RD_N && WR_N |=> !DATA_OE)
    else $error("bus held after strobe release");
  chk_idle_quiet: assert property (READ_TRANSFER_REQUEST_N && $past(READ_TRANSFER_REQUEST_N) |-> !DATA_OE)
    else $error("bus driven while idle");
  chk_req_held: assert property (!READ_TRANSFER_REQUEST_N && !(RD_N && WR_N) |=> !READ_TRANSFER_REQUEST_N)
    else $error("request dropped inside a strobe");
  chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response withdrawn");
  // main traffic seen
  cover property ($fell(READ_TRANSFER_REQUEST_N));
  cover property ($rose(DATA_OE) && !RD_N);
  cover property ($rose(DATA_OE) && !WR_N);
endmodule
bind rxdma_top rxdma_chk i_chk (
  .CLK_SYS(CLK_SYS),
  .RST_N(RST_N),
  .MSG_BYTE_VALID(MSG_BYTE_VALID),
  .MSG_END(MSG_END),
  .MSG_FULL(MSG_FULL),
  .READ_TRANSFER_ACK_N(READ_TRANSFER_ACK_N),
  .RD_N(RD_N),
  .WR_N(WR_N),
  .READ_TRANSFER_REQUEST_N(READ_TRANSFER_REQUEST_N),
  .DATA_OE(DATA_OE),
  .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY)
);

// >>> dv/rxdma_ctl_model.sv
`timescale 1ns/1ps
module rxdma_ctl_model (
  input wire logic clk,
  input wire logic req_n,
  input wire logic [7:0] data,
  input wire logic oe,
  input wire logic dir,
  input wire logic [3:0] lag,
  output logic ack_n,
  output logic rd_n,
  output logic wr_n
);
  logic [7:0] got [16];
  int n_got;
  int t;
  // answers a request, then strobes one byte at a time until it is withdrawn
  initial begin
    ack_n = 1;
    rd_n = 1;
    wr_n = 1;
    n_got = 0;
    forever begin
      @(negedge clk);
      if (!req_n) begin
        n_got = 0;
        repeat (lag) @(posedge clk);
        @(posedge clk) ack_n <= 0;
        do begin
          @(posedge clk);
          if (dir) wr_n <= 0;
          else rd_n <= 0;
          t = 0;
          do begin
            @(negedge clk);
            t++;
          end while (!oe && t < 8);
          got[n_got] = data;
          n_got++;
          @(posedge clk);
          rd_n <= 1;
          wr_n <= 1;
          @(negedge clk);
          @(negedge clk);
        end while (!req_n && n_got < 16);
        @(posedge clk) ack_n <= 1;
      end
    end
  end
endmodule

// >>> dv/tb_receive_dma_read_channel.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; $display("FAIL %0t got %h want %h", $time, a, b); end end
module tb_receive_dma_read_channel
  import rxdma_pkg::*;
;
  logic CLK_SYS = 0;
  logic RST_N = 0;
  logic [11:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [7:0] MSG_BYTE = 0, DATA_OUT;
  logic MSG_BYTE_VALID = 0, MSG_END = 0, MSG_FULL, READ_TRANSFER_ACK_N, RD_N, WR_N, READ_TRANSFER_REQUEST_N, DATA_OE;
  logic dir = 0;
  logic [3:0] lag = 0;
  int err_total = 0, n_compared = 0;
  // clock, design and far-side controller
  always #12.5 CLK_SYS = ~CLK_SYS;
  rxdma_top i_dut (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .MSG_BYTE(MSG_BYTE), .MSG_BYTE_VALID(MSG_BYTE_VALID), .MSG_END(MSG_END), .MSG_FULL(MSG_FULL),
    .READ_TRANSFER_ACK_N(READ_TRANSFER_ACK_N), .RD_N(RD_N), .WR_N(WR_N),
    .READ_TRANSFER_REQUEST_N(READ_TRANSFER_REQUEST_N), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));
  rxdma_ctl_model i_mdl (.clk(CLK_SYS), .req_n(READ_TRANSFER_REQUEST_N), .data(DATA_OUT), .oe(DATA_OE), .dir(dir),
    .lag(lag), .ack_n(READ_TRANSFER_ACK_N), .rd_n(RD_N), .wr_n(WR_N));
  task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [1:0] rs);
    int t = 0;
    S_AXI_AWADDR <= a;
    S_AXI_AWVALID <= 1;
    S_AXI_WDATA <= {24'h0000_00, d};
    S_AXI_WVALID <= 1;
    S_AXI_BREADY <= 1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
      t++;
    end while (!S_AXI_BVALID && t < 50);
    S_AXI_BREADY <= 0;
    `CHK({S_AXI_BVALID, S_AXI_BRESP}, {1'b1, rs})
    @(posedge CLK_SYS);
  endtask
  task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rs);
    int t = 0;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY <= 1;
    do begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
      t++;
    end while (!S_AXI_RVALID && t < 50);
    S_AXI_RREADY <= 0;
    `CHK({S_AXI_RVALID, S_AXI_RRESP, S_AXI_RDATA}, {1'b1, rs, d})
    @(posedge CLK_SYS);
  endtask
  // feed n bytes from base b, closing the message when fin is set
  task automatic msg(input int n, input logic [7:0] b, input logic fin);
    for (int i = 0; i < n; i++) begin
      MSG_BYTE <= b + i[7:0];
      MSG_BYTE_VALID <= 1;
      MSG_END <= fin && i == n - 1;
      @(posedge CLK_SYS);
    end
    MSG_BYTE_VALID <= 0;
    MSG_END <= 0;
    @(posedge CLK_SYS);
  endtask
  task automatic take(input int n, input logic [7:0] b);
    int t = 0;
    while (READ_TRANSFER_REQUEST_N && t < 40) begin
      @(posedge CLK_SYS);
      t++;
    end
    `CHK(READ_TRANSFER_REQUEST_N, 1'b0)
    while (!READ_TRANSFER_REQUEST_N && t < 600) begin
      @(posedge CLK_SYS);
      t++;
    end
    `CHK(i_mdl.n_got, n)
    for (int i = 0; i < n; i++) `CHK(i_mdl.got[i], b + i[7:0])
    repeat (2) @(posedge CLK_SYS);
    `CHK(MSG_FULL, 1'b0)
    `CHK(READ_TRANSFER_REQUEST_N, 1'b1)
  endtask
  task automatic t_regs;
    axr(RXDMA_CFG_ADDR, 32'h0000_0000, RXDMA_RESP_OKAY);
    axw(RXDMA_CFG_ADDR, 8'h7F, RXDMA_RESP_OKAY);
    axr(RXDMA_CFG_ADDR, 32'h0000_0067, RXDMA_RESP_OKAY);
    axw(12'h010, 8'h00, RXDMA_RESP_SLVERR);
    axr(12'h010, 32'h0000_0000, RXDMA_RESP_SLVERR);
  endtask
  task automatic t_gate;
    axw(RXDMA_CFG_ADDR, 8'h00, RXDMA_RESP_OKAY);
    msg(4, 8'hA0, 1);
    repeat (20) @(posedge CLK_SYS);
    `CHK({READ_TRANSFER_REQUEST_N, MSG_FULL}, 2'b11)
    axr(RXDMA_STAT_ADDR, 32'h0000_0002, RXDMA_RESP_OKAY);
    axr(RXDMA_MSG_ADDR, 32'h0000_0404, RXDMA_RESP_OKAY);
    for (int c = 3; c < 8; c++) begin
      axw(RXDMA_CFG_ADDR, 8'h40 | c[7:0], RXDMA_RESP_OKAY);
      repeat (10) @(posedge CLK_SYS);
      `CHK(READ_TRANSFER_REQUEST_N, 1'b1)
    end
    axw(RXDMA_CFG_ADDR, 8'h40, RXDMA_RESP_OKAY);
    take(4, 8'hA0);
  endtask
  task automatic t_part;
    msg(3, 8'hB0, 0);
    repeat (20) @(posedge CLK_SYS);
    `CHK({READ_TRANSFER_REQUEST_N, MSG_FULL}, 2'b10)
    msg(2, 8'hB3, 1);
    take(5, 8'hB0);
  endtask
  task automatic t_dir;
    dir <= 1;
    lag <= 4'h5;
    axw(RXDMA_CFG_ADDR, 8'h61, RXDMA_RESP_OKAY);
    msg(16, 8'h10, 1);
    take(16, 8'h10);
  endtask
  task automatic t_soft;
    dir <= 0;
    lag <= 4'h0;
    axw(RXDMA_CFG_ADDR, 8'h00, RXDMA_RESP_OKAY);
    msg(3, 8'hC0, 1);
    `CHK(MSG_FULL, 1'b1)
    axw(RXDMA_CFG_ADDR, 8'h80, RXDMA_RESP_OKAY);
    repeat (3) @(posedge CLK_SYS);
    `CHK(MSG_FULL, 1'b0)
    axw(RXDMA_CFG_ADDR, 8'h40, RXDMA_RESP_OKAY);
    repeat (10) @(posedge CLK_SYS);
    `CHK(READ_TRANSFER_REQUEST_N, 1'b1)
    msg(2, 8'hD0, 1);
    take(2, 8'hD0);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // reset for five cycles, wait out the internal release, run each scenario
  initial begin
    repeat (5) @(posedge CLK_SYS);
    RST_N <= 1;
    repeat (3) @(posedge CLK_SYS);
    t_regs();
    t_gate();
    t_part();
    t_dir();
    t_soft();
    complete_run();
  end
  // watchdog well beyond the expected few hundred cycles
  initial begin
    #500000;
    err_total++;
    complete_run();
  end
endmodule
